// ==== bench/fcsc_osc_model.sv ====
/*
  far side model: external oscillator start-up and the selected source clock.
  assumes the osc controls of fcsc_top and a tick interface synchronous to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module fcsc_osc_model
  import fcsc_pkg::*;
#(
  parameter int START_CYCLES = 16,
  parameter int TICK_DIV = 2
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire fcsc_osc_type osc,
  input wire logic run,
  output logic osc_running,
  output logic src_tick
);
  int start_q;
  int div_q;
  // no instant start: crystal needs a start-up count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 0;
      osc_running <= 1'b0;
    end else if (!osc.osc_enable) begin
      start_q <= 0;
      osc_running <= 1'b0;
    end else begin
      if (start_q < START_CYCLES) start_q <= start_q + 1;
      osc_running <= (start_q >= START_CYCLES);
    end
  end
  // source stands still while the system clock is gated
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 0;
      src_tick <= 1'b0;
    end else begin
      div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
      src_tick <= run && (div_q == TICK_DIV - 1);
    end
  end
endmodule : fcsc_osc_model
`default_nettype wire

// ==== bench/fll_clock_source_control_test.sv ====
/*
  self-checking bench for fcsc_top: wishbone tasks, one task per scenario.
  assumes fcsc_osc_model on the far side and the one-cycle registered ack.
*/
`timescale 1ns/10ps
`default_nettype none
module fll_clock_source_control_test;
  import fcsc_pkg::*;
  logic sys_clk, arst_n, we, cyc, stb, dbg, stop_rq, osc_run, tick, ack, bus_tick;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  logic [7:0] fine_period_adjust, q;
  fcsc_ctrl_type ctrl;
  fcsc_osc_type osc;
  fcsc_mode_type mode;
  int err_total, comparisons, cyc_cnt;

  fcsc_top DUT (.sys_clk(sys_clk), .arst_n(arst_n), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .debug_mode_active(dbg), .stop_request(stop_rq), .osc_running(osc_run), .factory_trim(fine_period_adjust),
    .src_tick(tick), .ctrl_out(ctrl), .osc_out(osc), .mode_out(mode), .bus_clk_tick(bus_tick));
  fcsc_osc_model far_side (.sys_clk(sys_clk), .arst_n(arst_n), .osc(osc), .run(ctrl.sysclk_enable),
    .osc_running(osc_run), .src_tick(tick));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {24'h00_0000, a};
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) chk(32'h0000_0000, 32'h0000_0001);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic settle;
    repeat (4) @(posedge sys_clk);
  endtask : settle

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic t_reset;
    chk({25'h0, mode}, {25'h0, FCSC_ENG_INT});
    wb(0, FCSC_OFF_CTRL1, 8'h00);
    chk({24'h0, q}, 32'h0000_0004);
    wb(0, FCSC_OFF_CTRL2, 8'h00);
    chk({24'h0, q}, 32'h0000_0040);
    wb(0, FCSC_OFF_TRIM, 8'h00);
    chk({24'h0, q}, {24'h0, fine_period_adjust});
    // unmapped place reads zero
    wb(1, 8'h10, 8'hFF);
    wb(0, 8'h10, 8'h00);
    chk({24'h0, q}, 32'h0000_0000);
  endtask : t_reset

  task automatic mode_case(input logic [7:0] c1, input logic [7:0] c2, input logic d, input fcsc_mode_type m,
    input logic [1:0] src, input logic fll, input logic dbc, input logic ri);
    dbg <= d;
    wb(1, FCSC_OFF_CTRL2, c2);
    wb(1, FCSC_OFF_CTRL1, c1);
    settle;
    chk({25'h0, mode}, {25'h0, m});
    chk({26'h0, ctrl.src_sel, ctrl.fll_enable, ctrl.debug_clk_enable, ctrl.fll_ref_internal,
      ctrl.sysclk_enable}, {26'h0, src, fll, dbc, ri, 1'b1});
    wb(0, FCSC_OFF_STAT, 8'h00);
    chk({30'h0, q[3:2]}, {30'h0, src});
  endtask : mode_case

  task automatic t_ref_divider;
    logic [4:0] e;
    for (int r = 0; r < 2; r++) begin
      for (int d = 0; d < 8; d++) begin
        wb(1, FCSC_OFF_CTRL2, {2'b01, r[0], 5'h00});
        wb(1, FCSC_OFF_CTRL1, {2'b00, d[2:0], 3'b100});
        settle;
        e = (r == 1) ? ((d > 5) ? 5'h0A : 5'(d + 5)) : 5'(d);
        chk({27'h0, ctrl.ref_div_log2}, {27'h0, e});
        chk({31'h0, osc.high_range}, {31'h0, r[0]});
      end
    end
  endtask : t_ref_divider

  task automatic t_bus_divider;
    int n, s;
    for (int b = 0; b < 4; b++) begin
      wb(1, FCSC_OFF_CTRL2, {b[1:0], 6'h00});
      settle;
      n = 0;
      while (bus_tick !== 1'b1 && n < 64) begin
        @(posedge sys_clk);
        n++;
      end
      s = 0;
      n = 0;
      do begin
        @(posedge sys_clk);
        if (tick === 1'b1) s++;
        n++;
      end while (bus_tick !== 1'b1 && n < 64);
      chk(32'(s), 32'(1 << b));
    end
  endtask : t_bus_divider

  task automatic t_osc;
    wb(1, FCSC_OFF_CTRL1, 8'h06);
    wb(1, FCSC_OFF_CTRL2, 8'h76);
    settle;
    chk({28'h0, osc}, 32'h0000_000F);
    chk({30'h0, ctrl.int_ref_out_en, ctrl.ext_ref_out_en}, 32'h0000_0003);
    // start-up count plus synchroniser plus the 64-cycle settle count, with margin
    repeat (120) @(posedge sys_clk);
    wb(0, FCSC_OFF_STAT, 8'h00);
    chk({31'h0, q[1]}, 32'h0000_0001);
    wb(1, FCSC_OFF_CTRL1, 8'h04);
    wb(1, FCSC_OFF_CTRL2, 8'h40);
    settle;
    chk({28'h0, osc}, 32'h0000_0000);
    chk({30'h0, ctrl.int_ref_out_en, ctrl.ext_ref_out_en}, 32'h0000_0000);
  endtask : t_osc

  task automatic t_trim;
    wb(1, FCSC_OFF_TRIM, 8'hC3);
    wb(1, FCSC_OFF_STAT, 8'h21);
    settle;
    wb(0, FCSC_OFF_TRIM, 8'h00);
    chk({24'h0, q}, 32'h0000_00C3);
    chk({23'h0, ctrl.trim_word}, {23'h0, 8'hC3, 1'b1});
    chk({21'h0, ctrl.fll_mult}, {21'h0, FCSC_FLL_MULT_32K});
    wb(1, FCSC_OFF_STAT, 8'h00);
    settle;
    chk({23'h0, ctrl.trim_word}, {23'h0, 8'hC3, 1'b0});
    chk({21'h0, ctrl.fll_mult}, {21'h0, FCSC_FLL_MULT});
  endtask : t_trim

  task automatic t_stop(input logic [7:0] c1, input logic [7:0] c2, input logic [1:0] keep);
    wb(1, FCSC_OFF_CTRL1, c1);
    wb(1, FCSC_OFF_CTRL2, c2);
    settle;
    stop_rq <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({25'h0, mode}, {25'h0, FCSC_STOP});
    chk({29'h0, ctrl.fll_enable, ctrl.sysclk_enable, ctrl.debug_clk_enable}, 32'h0000_0000);
    chk({30'h0, ctrl.int_ref_run, osc.osc_enable}, {30'h0, keep});
    stop_rq <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({25'h0, mode}, {25'h0, FCSC_ENG_INT});
    chk({31'h0, ctrl.debug_clk_enable}, 32'h0000_0000);
    // relock wait outlasts the lock count
    repeat (1100) @(posedge sys_clk);
    chk({31'h0, ctrl.debug_clk_enable}, 32'h0000_0001);
  endtask : t_stop

  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      tally_and_finish;
    end
  end

  initial begin
    {we, cyc, stb, dbg, stop_rq} = 5'h00;
    {adr, wdat} = 64'h0000_0000_0000_0000;
    sel = 4'hF;
    fine_period_adjust = 8'h5A;
    arst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset;
    mode_case(8'h44, 8'h40, 1'b0, FCSC_BYP_INT, 2'b01, 1'b1, 1'b1, 1'b1);
    mode_case(8'h80, 8'h40, 1'b0, FCSC_BYP_EXT, 2'b10, 1'b1, 1'b1, 1'b0);
    mode_case(8'hC4, 8'h40, 1'b0, FCSC_ENG_INT, 2'b00, 1'b1, 1'b1, 1'b1);
    // divide by one assumes a reference already in the 32 kHz band
    mode_case(8'h00, 8'h40, 1'b0, FCSC_ENG_EXT, 2'b00, 1'b1, 1'b1, 1'b0);
    mode_case(8'h44, 8'h48, 1'b0, FCSC_BYP_INT_LOW, 2'b01, 1'b0, 1'b0, 1'b1);
    mode_case(8'h80, 8'h48, 1'b0, FCSC_BYP_EXT_LOW, 2'b10, 1'b0, 1'b0, 1'b0);
    mode_case(8'h44, 8'h48, 1'b1, FCSC_BYP_INT, 2'b01, 1'b1, 1'b1, 1'b1);
    mode_case(8'h04, 8'h40, 1'b0, FCSC_ENG_INT, 2'b00, 1'b1, 1'b1, 1'b1);
    t_ref_divider;
    t_bus_divider;
    t_osc;
    t_trim;
    t_stop(8'h07, 8'h46, 2'b10);
    t_stop(8'h06, 8'h47, 2'b01);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    dbg <= 1'b1;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    wb(0, FCSC_OFF_TRIM, 8'h00);
    chk({24'h0, q}, {24'h0, FCSC_TRIM_DEBUG});
    tally_and_finish;
  end
endmodule : fll_clock_source_control_test
`default_nettype wire

// ==== rtl/fcsc_pkg.sv ====
/*
  constants and carrier types for the clock generator control block.
  assumes a classic wishbone slave on sys_clk with 8-bit registers in the low byte of 32-bit words.
*/
package fcsc_pkg;
  localparam logic [7:0] FCSC_OFF_CTRL1 = 8'h00;
  localparam logic [7:0] FCSC_OFF_CTRL2 = 8'h04;
  localparam logic [7:0] FCSC_OFF_TRIM = 8'h08;
  localparam logic [7:0] FCSC_OFF_STAT = 8'h0C;
  localparam logic [7:0] FCSC_RST_CTRL1 = 8'h04;
  localparam logic [7:0] FCSC_RST_CTRL2 = 8'h40;
  localparam logic [7:0] FCSC_RST_STAT = 8'h10;
  localparam logic [7:0] FCSC_TRIM_DEBUG = 8'h80;
  localparam logic [7:0] FCSC_TRIM_FACTORY_DEFAULT = 8'h80;
  localparam logic [1:0] FCSC_TRIM_SETTLE = 2'h2;
  localparam logic [10:0] FCSC_FLL_MULT = 11'h200;
  localparam logic [10:0] FCSC_FLL_MULT_32K = 11'h260;
  localparam int FCSC_SRC_MSB = 7;
  localparam int FCSC_SRC_LSB = 6;
  localparam int FCSC_REFDIV_MSB = 5;
  localparam int FCSC_REFDIV_LSB = 3;
  localparam int FCSC_REFSEL_BIT = 2;
  localparam int FCSC_INTOUT_BIT = 1;
  localparam int FCSC_IRSTEN_BIT = 0;
  localparam int FCSC_BUSDIV_MSB = 7;
  localparam int FCSC_BUSDIV_LSB = 6;
  localparam int FCSC_RANGE_BIT = 5;
  localparam int FCSC_GAIN_BIT = 4;
  localparam int FCSC_LOWPWR_BIT = 3;
  localparam int FCSC_XTAL_BIT = 2;
  localparam int FCSC_EXTOUT_BIT = 1;
  localparam int FCSC_ERSTEN_BIT = 0;
  localparam int FCSC_DMX_BIT = 5;
  localparam int FCSC_FINE_BIT = 0;
  localparam logic [2:0] FCSC_REFDIV_HI_LIMIT = 3'h5;
  localparam logic [4:0] FCSC_REFDIV_HI_SHIFT = 5'h05;
  localparam logic [7:0] FCSC_OSC_INIT_CYCLES = 8'h40;
  localparam logic [10:0] FCSC_FLL_LOCK_CYCLES = 11'h400;

  typedef enum logic [6:0] {
    FCSC_ENG_INT = 7'b000_0001,
    FCSC_ENG_EXT = 7'b000_0010,
    FCSC_BYP_INT = 7'b000_0100,
    FCSC_BYP_INT_LOW = 7'b000_1000,
    FCSC_BYP_EXT = 7'b001_0000,
    FCSC_BYP_EXT_LOW = 7'b010_0000,
    FCSC_STOP = 7'b100_0000
  } fcsc_mode_type;

  typedef struct packed {
    logic high_range;
    logic high_gain;
    logic source_is_crystal;
    logic osc_enable;
  } fcsc_osc_type;

  typedef struct packed {
    logic fll_enable;
    logic fll_ref_internal;
    logic [10:0] fll_mult;
    logic [1:0] src_sel;
    logic sysclk_enable;
    logic debug_clk_enable;
    logic int_ref_run;
    logic int_ref_out_en;
    logic ext_ref_out_en;
    logic [4:0] ref_div_log2;
    logic [8:0] trim_word;
  } fcsc_ctrl_type;
endpackage : fcsc_pkg

// ==== rtl/fcsc_top.sv ====
/*
  clock generator control: register file, mode decode, reference and bus dividers.
  assumes reference and fll clocks are handled by analog cells driven from these controls;
  selected clock arrives as src_tick enables already in sys_clk domain.
*/
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module fcsc_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic debug_mode_active,
  input wire logic stop_request,
  input wire logic osc_running,
  input wire logic [7:0] factory_trim,
  input wire logic src_tick,
  output var fcsc_pkg::fcsc_ctrl_type ctrl_out,
  output var fcsc_pkg::fcsc_osc_type osc_out,
  output var fcsc_pkg::fcsc_mode_type mode_out,
  output logic bus_clk_tick
);
  import fcsc_pkg::*;

  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] trim_q;
  logic dmx_q;
  logic fine_q;
  logic [1:0] clk_status_q;
  logic ref_status_q;
  logic osc_ready_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic dbg_s1_q, dbg_s2_q, stop_s1_q, stop_s2_q, osc_s1_q, osc_s2_q;
  logic trim_loaded_q;
  logic [1:0] trim_wait_q;
  logic int_keep_q, ext_keep_q;
  logic [7:0] osc_cnt_q;
  logic [10:0] lock_cnt_q;
  logic [2:0] bus_divider_cnt_q;
  logic [1:0] sel_stage_q;
  fcsc_mode_type mode_q, mode_d;
  fcsc_ctrl_type ctrl_q;
  fcsc_osc_type osc_q;
  logic bus_tick_q;

  wire wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
  wire rd_stb = wb_cyc_i && wb_stb_i && !ack_q;
  wire [1:0] src_sel = ctrl1_q[FCSC_SRC_MSB:FCSC_SRC_LSB];
  wire fll_int = ctrl1_q[FCSC_REFSEL_BIT];
  wire low_pwr = ctrl2_q[FCSC_LOWPWR_BIT] && !dbg_s2_q;

  function automatic logic [4:0] ref_div_log2(input logic [2:0] code, input logic hi);
    ref_div_log2 = hi ? 5'(code) + FCSC_REFDIV_HI_SHIFT : 5'(code);
  endfunction : ref_div_log2

  // pin inputs double synchronised
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {dbg_s1_q, dbg_s2_q, stop_s1_q, stop_s2_q, osc_s1_q, osc_s2_q} <= 6'h00;
    end else begin
      dbg_s1_q <= debug_mode_active;
      dbg_s2_q <= dbg_s1_q;
      stop_s1_q <= stop_request;
      stop_s2_q <= stop_s1_q;
      osc_s1_q <= osc_running;
      osc_s2_q <= osc_s1_q;
    end
  end

  // wishbone classic, ack one cycle after strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= rd_stb;
      if (rd_stb) begin
        unique case (wb_adr_i[7:0])
          FCSC_OFF_CTRL1: rdata_q <= {24'h00_0000, ctrl1_q};
          FCSC_OFF_CTRL2: rdata_q <= {24'h00_0000, ctrl2_q};
          FCSC_OFF_TRIM: rdata_q <= {24'h00_0000, trim_q};
          FCSC_OFF_STAT: rdata_q <= {24'h00_0000, 2'b00, dmx_q, ref_status_q, clk_status_q, osc_ready_q, fine_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1_q <= FCSC_RST_CTRL1;
    end else if (wr_stb && wb_adr_i[7:0] == FCSC_OFF_CTRL1) begin
      ctrl1_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl2_q <= FCSC_RST_CTRL2;
    end else if (wr_stb && wb_adr_i[7:0] == FCSC_OFF_CTRL2) begin
      ctrl2_q <= wb_dat_i[7:0];
    end
  end

  // trim caught once synced debug settles; debug forces 0x80
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_q <= FCSC_TRIM_FACTORY_DEFAULT;
      trim_loaded_q <= 1'b0;
      trim_wait_q <= 2'h0;
    end else if (!trim_loaded_q) begin
      if (trim_wait_q == FCSC_TRIM_SETTLE) begin
        trim_loaded_q <= 1'b1;
        trim_q <= dbg_s2_q ? FCSC_TRIM_DEBUG : factory_trim;
      end else begin
        trim_wait_q <= trim_wait_q + 2'h1;
      end
    end else if (wr_stb && wb_adr_i[7:0] == FCSC_OFF_TRIM) begin
      trim_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dmx_q <= 1'b0;
      fine_q <= 1'b0;
    end else if (wr_stb && wb_adr_i[7:0] == FCSC_OFF_STAT) begin
      dmx_q <= wb_dat_i[FCSC_DMX_BIT];
      fine_q <= wb_dat_i[FCSC_FINE_BIT];
    end
  end

  always_comb begin
    mode_d = FCSC_ENG_INT;
    if (stop_s2_q) begin
      mode_d = FCSC_STOP;
    end else begin
      unique case (src_sel)
        2'b01: mode_d = low_pwr ? FCSC_BYP_INT_LOW : FCSC_BYP_INT;
        2'b10: mode_d = low_pwr ? FCSC_BYP_EXT_LOW : FCSC_BYP_EXT;
        default: mode_d = fll_int ? FCSC_ENG_INT : FCSC_ENG_EXT;
      endcase
    end
  end

  // reset mode; lock restart on stop exit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= FCSC_ENG_INT;
      lock_cnt_q <= 11'h000;
    end else begin
      mode_q <= mode_d;
      if (mode_q == FCSC_STOP && mode_d != FCSC_STOP) begin
        lock_cnt_q <= FCSC_FLL_LOCK_CYCLES;
      end else if (lock_cnt_q != 11'h000) begin
        lock_cnt_q <= lock_cnt_q - 11'h001;
      end
    end
  end

  // keep bits sampled on stop entry
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_keep_q <= 1'b0;
      ext_keep_q <= 1'b0;
    end else if (mode_q != FCSC_STOP && mode_d == FCSC_STOP) begin
      int_keep_q <= ctrl1_q[FCSC_IRSTEN_BIT] && ctrl1_q[FCSC_INTOUT_BIT];
      ext_keep_q <= ctrl2_q[FCSC_ERSTEN_BIT] && ctrl2_q[FCSC_EXTOUT_BIT];
    end
  end

  // status trails select by two stages
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_stage_q <= 2'b00;
      clk_status_q <= 2'b00;
      ref_status_q <= FCSC_RST_STAT[4];
    end else begin
      sel_stage_q <= (src_sel == 2'b11) ? 2'b00 : src_sel;
      clk_status_q <= sel_stage_q;
      ref_status_q <= ctrl_q.fll_ref_internal;
    end
  end

  // oscillator ready after settle count; cleared by enable or crystal clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_q <= 8'h00;
      osc_ready_q <= 1'b0;
    end else if (!osc_q.source_is_crystal || !osc_q.osc_enable) begin
      osc_cnt_q <= 8'h00;
      osc_ready_q <= 1'b0;
    end else if (osc_s2_q && osc_cnt_q != FCSC_OSC_INIT_CYCLES) begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
    end else if (osc_cnt_q == FCSC_OSC_INIT_CYCLES) begin
      osc_ready_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= '0;
      osc_q <= '0;
    end else begin
      ctrl_q.fll_enable <= mode_q inside {FCSC_ENG_INT, FCSC_ENG_EXT, FCSC_BYP_INT, FCSC_BYP_EXT};
      ctrl_q.debug_clk_enable <= mode_q inside {FCSC_ENG_INT, FCSC_ENG_EXT, FCSC_BYP_INT, FCSC_BYP_EXT}
        && lock_cnt_q == 11'h000;
      ctrl_q.sysclk_enable <= mode_q != FCSC_STOP;
      ctrl_q.fll_ref_internal <= fll_int;
      ctrl_q.fll_mult <= dmx_q ? FCSC_FLL_MULT_32K : FCSC_FLL_MULT;
      ctrl_q.src_sel <= sel_stage_q;
      ctrl_q.int_ref_run <= mode_q == FCSC_STOP ? int_keep_q : 1'b1;
      ctrl_q.int_ref_out_en <= ctrl1_q[FCSC_INTOUT_BIT] && (mode_q != FCSC_STOP || int_keep_q);
      ctrl_q.ext_ref_out_en <= ctrl2_q[FCSC_EXTOUT_BIT] && (mode_q != FCSC_STOP || ext_keep_q);
      ctrl_q.ref_div_log2 <= ref_div_log2(
        (ctrl2_q[FCSC_RANGE_BIT] && ctrl1_q[FCSC_REFDIV_MSB:FCSC_REFDIV_LSB] > FCSC_REFDIV_HI_LIMIT)
          ? FCSC_REFDIV_HI_LIMIT : ctrl1_q[FCSC_REFDIV_MSB:FCSC_REFDIV_LSB], ctrl2_q[FCSC_RANGE_BIT]);
      // trim word, fine bit as lsb
      ctrl_q.trim_word <= {trim_q, fine_q};
      osc_q.high_range <= ctrl2_q[FCSC_RANGE_BIT];
      osc_q.high_gain <= ctrl2_q[FCSC_GAIN_BIT];
      osc_q.source_is_crystal <= ctrl2_q[FCSC_XTAL_BIT];
      osc_q.osc_enable <= mode_q == FCSC_STOP ? ext_keep_q
        : (ctrl2_q[FCSC_EXTOUT_BIT] || mode_q inside {FCSC_ENG_EXT, FCSC_BYP_EXT, FCSC_BYP_EXT_LOW});
    end
  end

  // bus divider counts source ticks, ratio change takes effect at once
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_divider_cnt_q <= 3'h0;
      bus_tick_q <= 1'b0;
    end else begin
      bus_tick_q <= 1'b0;
      if (src_tick && ctrl_q.sysclk_enable) begin
        unique case (ctrl2_q[FCSC_BUSDIV_MSB:FCSC_BUSDIV_LSB])
          2'b00: bus_tick_q <= 1'b1;
          2'b01: bus_tick_q <= bus_divider_cnt_q[0];
          2'b10: bus_tick_q <= &bus_divider_cnt_q[1:0];
          2'b11: bus_tick_q <= &bus_divider_cnt_q;
        endcase
        bus_divider_cnt_q <= bus_divider_cnt_q + 3'h1;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign ctrl_out = ctrl_q;
  assign osc_out = osc_q;
  assign mode_out = mode_q;
  assign bus_clk_tick = bus_tick_q;

  // low power internal has no fll
  AST_INT_LOW_NO_FLL: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode_q == FCSC_BYP_INT_LOW |=> !ctrl_q.fll_enable && !ctrl_q.debug_clk_enable)
    else $error("fll running in internal low power bypass");
  AST_EXT_LOW_NO_FLL: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode_q == FCSC_BYP_EXT_LOW |=> !ctrl_q.fll_enable && !ctrl_q.debug_clk_enable)
    else $error("fll running in external low power bypass");
  AST_BYP_INT_FLL_ON: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode_q == FCSC_BYP_INT |=> ctrl_q.fll_enable)
    else $error("fll off in internal bypass");
  AST_BYP_EXT_FLL_ON: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode_q == FCSC_BYP_EXT |=> ctrl_q.fll_enable)
    else $error("fll off in external bypass");
  AST_STOP_NO_CLK: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode_q == FCSC_STOP |=> !ctrl_q.sysclk_enable && !ctrl_q.fll_enable)
    else $error("clock running in stop");
  AST_LOWPWR_DEBUG: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !stop_s2_q && src_sel == 2'b01 && dbg_s2_q |=> mode_q == FCSC_BYP_INT)
    else $error("debug did not hold fll in bypass");
  AST_STATUS_LAG: assert property (@(posedge sys_clk) disable iff (!arst_n)
    src_sel == 2'b10 ##1 src_sel == 2'b10 |=> clk_status_q == 2'b10)
    else $error("status missed external select");
  AST_INT_STOP: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode_q == FCSC_STOP && !int_keep_q |=> !ctrl_q.int_ref_out_en)
    else $error("internal reference out in stop without keep");
  AST_BDIV1: assert property (@(posedge sys_clk) disable iff (!arst_n)
    src_tick && ctrl_q.sysclk_enable && ctrl2_q[7:6] == 2'b00 |=> bus_tick_q)
    else $error("divide by one missed tick");
endmodule : fcsc_top
`default_nettype wire
